// file: verilog/mrc_pkg.sv
package mrc_pkg;

  // oscillator source selection
  typedef enum logic [1:0] {
    MRC_OSC_FAST_XTAL,
    MRC_OSC_SLOW_XTAL,
    MRC_OSC_EXT_RC,
    MRC_OSC_INT_RC
  } mrc_osc_e;

  // reset sequencer states
  typedef enum logic [1:0] {
    MRC_ST_HOLD,
    MRC_ST_STARTUP,
    MRC_ST_RELEASE,
    MRC_ST_RUN
  } mrc_state_e;

  // reset cause class latched while the reset is held
  typedef enum logic [1:0] {
    MRC_CAUSE_POWER,
    MRC_CAUSE_PIN,
    MRC_CAUSE_WDT_RUN,
    MRC_CAUSE_WDT_SLEEP
  } mrc_cause_e;

  localparam int MRC_CLK_MHZ = 100;
  localparam int MRC_STARTUP_LONG_CYCLES = 1024;
  localparam int MRC_STARTUP_SHORT_CYCLES = 2;
  localparam int MRC_RELEASE_DELAY_MS = 100;
  localparam int MRC_RELEASE_DELAY_CYCLES =
    MRC_RELEASE_DELAY_MS * 1000 * MRC_CLK_MHZ;
  localparam int MRC_LOW_SUPPLY_MIN_NS = 1000;
  localparam int MRC_LOW_SUPPLY_MIN_CYCLES =
    (MRC_LOW_SUPPLY_MIN_NS * MRC_CLK_MHZ + 999) / 1000;
  localparam int MRC_CNT_W = 32;

  // reset values per register
  localparam logic [7:0] MRC_PORT_RST = 8'hFF;
  localparam logic [7:0] MRC_SYSCTRL2_RST = 8'h8A;
  localparam logic [7:0] MRC_TIMER0_CTRL_RST = 8'h08;
  localparam logic [7:0] MRC_CONV_CTRL_RST = 8'h40;
  localparam logic [7:0] MRC_INT_EN_RST = 8'h00;
  localparam logic [7:0] MRC_PC_RST = 8'h00;
  localparam logic [2:0] MRC_SP_TOP = 3'h5;
  localparam logic [7:0] MRC_PRESCALE_RST = 8'h00;

endpackage

// file: verilog/mrc_sync.sv
`timescale 1ns/1ps
module mrc_sync
  import mrc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw and filtered level
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic [2:0] sh;
    logic q;
  } mrc_sync_s;

  mrc_sync_s st_r;
  mrc_sync_s st_nxt;

  // stage 0 only feeds stage 1; stages 1 and 2 must agree to change
  always_comb begin
    st_nxt = st_r;
    st_nxt.sh = {st_r.sh[1:0], din};
    if (st_r.sh[1] == st_r.sh[2]) begin
      st_nxt.q = st_r.sh[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {{3{RST_VAL}}, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule

// file: verilog/mrc_reset_ctrl.sv
// Operation
// [R1] reset while supply is low and the low-supply reset is enabled
// [R2] a low-supply dip not longer than the minimum time is ignored
// [R3] enable and threshold of low-supply reset come from configuration
// [R4] running watchdog time-out resets like the pin, also sets timeout
// [R5] sleeping watchdog time-out clears only pc and stack, sets timeout
// [R6] rc clock sources choose 1024 or 2 start-up cycles
// [R7] crystal clock sources always use 1024 start-up cycles
// [R8] an extra release delay of 100 ms follows removal of the cause
// [R9] flags: power clears both, pin keeps, watchdog sets per mode
// [R10] power-on gives pc zero and stack pointer at the top
// [R11] power-on clears every interrupt enable
// [R12] any reset clears the watchdog counter, restarting after
// [R13] power-on stops both timer/event counters
// [R14] power-on clears the timer prescalers
// [R15] full resets set port direction and data latches to all ones
// [R16] full resets load control register defaults
// [R17] data registers retained or undefined; left to the core
// [R18] holding the reset pin low restarts execution from address zero
// [R19] all causes merge into one reset released on the clock
`timescale 1ns/1ps
module mrc_reset_ctrl
  import mrc_pkg::*;
#(
  parameter int RELEASE_CYCLES = MRC_RELEASE_DELAY_CYCLES
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // reset causes
  input wire logic external_reset_pin_n,
  input wire logic supply_low,
  input wire logic watchdog_timeout,
  input wire logic sleep_mode,
  // configuration options
  input wire logic low_supply_reset_en,
  input wire logic [1:0] low_supply_threshold_cfg,
  input wire mrc_osc_e osc_select,
  input wire logic short_startup_cfg,
  // threshold selection sent to the analog supply detector
  output logic [1:0] low_supply_threshold,
  // reset to the core
  output logic core_reset_n,
  output logic full_reset_pulse,
  output logic sleep_wake_reset_pulse,
  output logic watchdog_clear,
  // status flags
  output logic watchdog_timeout_flag,
  output logic powerdown_flag,
  input wire logic powerdown_set,
  input wire logic flags_clear,
  // values loaded on reset
  output logic [7:0] pc_reset_value,
  output logic [2:0] sp_reset_value,
  output logic [7:0] int_enable_value,
  output logic timers_stopped,
  output logic [7:0] prescaler_value,
  output logic [7:0] port_dir_value,
  output logic [7:0] port_data_value,
  output logic [7:0] system_control_second,
  output logic [7:0] timer0_control,
  output logic [7:0] converter_control
);

  typedef struct packed {
    mrc_state_e state;
    mrc_cause_e cause;
    logic [MRC_CNT_W-1:0] cnt;
    logic [MRC_CNT_W-1:0] low_cnt;
    logic low_qual;
    logic wdt_d;
    logic core_rst_n;
    logic full_pulse;
    logic wake_pulse;
    logic wdt_clr;
    logic to_flag;
    logic pd_flag;
    logic [1:0] thr;
  } mrc_ctrl_s;

  mrc_ctrl_s st_r;
  mrc_ctrl_s st_nxt;

  default clocking mrc_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic pin_n_s;
  logic low_s;

  // pin and analog detector come from outside the clock domain
  mrc_sync #(.RST_VAL(1'b0)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(external_reset_pin_n),
    .dout(pin_n_s)
  );

  mrc_sync #(.RST_VAL(1'b0)) u_low_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(supply_low),
    .dout(low_s)
  );

  function automatic logic [MRC_CNT_W-1:0] startup_len(
    input mrc_osc_e osc,
    input logic short_cfg
  );
    logic rc_src;
    rc_src = (osc == MRC_OSC_EXT_RC) || (osc == MRC_OSC_INT_RC);
    if (rc_src && short_cfg) begin // see [R6]
      startup_len = MRC_CNT_W'(MRC_STARTUP_SHORT_CYCLES);
    end else begin // see [R7]
      startup_len = MRC_CNT_W'(MRC_STARTUP_LONG_CYCLES);
    end
  endfunction

  logic wdt_evt;
  logic hold_req;

  assign wdt_evt = watchdog_timeout && !st_r.wdt_d;
  // qualified low supply only counts while the option is on
  assign hold_req = !pin_n_s // see [R18]
    || (st_r.low_qual && low_supply_reset_en); // see [R1]

  always_comb begin
    st_nxt = st_r;
    st_nxt.wdt_d = watchdog_timeout;
    st_nxt.full_pulse = 1'b0;
    st_nxt.wake_pulse = 1'b0;
    st_nxt.wdt_clr = 1'b0;
    st_nxt.thr = low_supply_threshold_cfg; // see [R3]
    // dip must last longer than the minimum before it qualifies
    if (low_s) begin // see [R2]
      if (st_r.low_cnt < MRC_CNT_W'(MRC_LOW_SUPPLY_MIN_CYCLES)) begin
        st_nxt.low_cnt = st_r.low_cnt + MRC_CNT_W'(1);
      end else begin
        st_nxt.low_qual = 1'b1;
      end
    end else begin
      st_nxt.low_cnt = '0;
      st_nxt.low_qual = 1'b0;
    end
    if (powerdown_set) begin
      st_nxt.pd_flag = 1'b1;
    end else if (flags_clear) begin
      st_nxt.pd_flag = 1'b0;
    end
    if (flags_clear) begin
      st_nxt.to_flag = 1'b0;
    end
    case (st_r.state)
      MRC_ST_HOLD: begin
        st_nxt.core_rst_n = 1'b0;
        st_nxt.wdt_clr = 1'b1; // see [R12]
        if (!hold_req) begin
          st_nxt.state = MRC_ST_STARTUP;
          st_nxt.cnt = startup_len(osc_select, short_startup_cfg);
        end
      end
      MRC_ST_STARTUP: begin
        st_nxt.core_rst_n = 1'b0;
        st_nxt.wdt_clr = 1'b1;
        if (hold_req) begin
          st_nxt.state = MRC_ST_HOLD;
        end else if (st_r.cnt <= MRC_CNT_W'(1)) begin
          st_nxt.state = MRC_ST_RELEASE;
          st_nxt.cnt = MRC_CNT_W'(RELEASE_CYCLES);
        end else begin
          st_nxt.cnt = st_r.cnt - MRC_CNT_W'(1);
        end
      end
      MRC_ST_RELEASE: begin
        st_nxt.core_rst_n = 1'b0;
        st_nxt.wdt_clr = 1'b1;
        if (hold_req) begin
          st_nxt.state = MRC_ST_HOLD;
        end else if (st_r.cnt <= MRC_CNT_W'(1)) begin // see [R8]
          st_nxt.state = MRC_ST_RUN;
          st_nxt.core_rst_n = 1'b1; // see [R19]
          st_nxt.full_pulse = (st_r.cause != MRC_CAUSE_WDT_SLEEP);
          st_nxt.wake_pulse = (st_r.cause == MRC_CAUSE_WDT_SLEEP);
        end else begin
          st_nxt.cnt = st_r.cnt - MRC_CNT_W'(1);
        end
      end
      default: begin
        if (hold_req) begin
          st_nxt.state = MRC_ST_HOLD;
          st_nxt.cause = MRC_CAUSE_PIN;
          st_nxt.core_rst_n = 1'b0;
        end else if (wdt_evt) begin
          st_nxt.core_rst_n = 1'b0;
          st_nxt.to_flag = 1'b1; // see [R9]
          if (sleep_mode) begin // see [R5]
            st_nxt.cause = MRC_CAUSE_WDT_SLEEP;
            st_nxt.pd_flag = 1'b1;
            st_nxt.state = MRC_ST_STARTUP;
            st_nxt.cnt = startup_len(osc_select, short_startup_cfg);
          end else begin // see [R4]
            st_nxt.cause = MRC_CAUSE_WDT_RUN;
            st_nxt.state = MRC_ST_HOLD;
          end
        end
      end
    endcase
    // a pin or supply reset during a sleep wake becomes a full reset
    if (hold_req && st_r.state != MRC_ST_RUN &&
        st_r.cause == MRC_CAUSE_WDT_SLEEP) begin
      st_nxt.cause = MRC_CAUSE_PIN;
    end
    // the watchdog stays cleared on every cycle the core is held
    st_nxt.wdt_clr = !st_nxt.core_rst_n; // see [R12]
  end

  // power-on state: both flags clear, cause is power
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: MRC_ST_HOLD, cause: MRC_CAUSE_POWER,
                cnt: '0, low_cnt: '0, low_qual: 1'b0, wdt_d: 1'b0,
                core_rst_n: 1'b0, full_pulse: 1'b0, wake_pulse: 1'b0,
                wdt_clr: 1'b1, to_flag: 1'b0, pd_flag: 1'b0,
                thr: 2'h0}; // see [R9]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign low_supply_threshold = st_r.thr; // see [R3]
  assign core_reset_n = st_r.core_rst_n;
  assign full_reset_pulse = st_r.full_pulse;
  assign sleep_wake_reset_pulse = st_r.wake_pulse;
  assign watchdog_clear = st_r.wdt_clr;
  assign watchdog_timeout_flag = st_r.to_flag;
  assign powerdown_flag = st_r.pd_flag;
  // load values, constant except timers_stopped; the core samples them on its reset pulses
  assign pc_reset_value = MRC_PC_RST; // see [R10]
  assign sp_reset_value = MRC_SP_TOP; // see [R10]
  assign int_enable_value = MRC_INT_EN_RST; // see [R11]
  assign timers_stopped = !st_r.core_rst_n; // see [R13]
  assign prescaler_value = MRC_PRESCALE_RST; // see [R14]
  assign port_dir_value = MRC_PORT_RST; // see [R15]
  assign port_data_value = MRC_PORT_RST; // see [R15]
  assign system_control_second = MRC_SYSCTRL2_RST; // see [R16]
  assign timer0_control = MRC_TIMER0_CTRL_RST; // see [R16]
  assign converter_control = MRC_CONV_CTRL_RST; // see [R16]

  sequence release_wait_s;
    st_r.state == MRC_ST_RELEASE && !hold_req;
  endsequence

  sequence run_wdt_s;
    st_r.state == MRC_ST_RUN && !hold_req && wdt_evt;
  endsequence

  sequence hold_leave_s;
    st_r.state == MRC_ST_HOLD && !hold_req;
  endsequence

  property low_dip_p;
    !low_s |=> !st_r.low_qual;
  endproperty

  low_dip_filter_a: assert property (low_dip_p) // see [R2]
    else $error("short low supply qualified");

  low_dip_short_a: assert property ( // see [R2]
    (low_s && !st_r.low_qual &&
     st_r.low_cnt < MRC_CNT_W'(MRC_LOW_SUPPLY_MIN_CYCLES))
    |=> !st_r.low_qual)
    else $error("dip qualified before minimum time");

  low_supply_hold_a: assert property ( // see [R1]
    (st_r.state == MRC_ST_RUN && st_r.low_qual && low_supply_reset_en)
    |=> !core_reset_n)
    else $error("low supply did not reset");

  run_wdt_flag_a: assert property ( // see [R4]
    run_wdt_s ##0 !sleep_mode
    |=> watchdog_timeout_flag && st_r.state == MRC_ST_HOLD)
    else $error("running watchdog reset wrong");

  sleep_wdt_flags_a: assert property ( // see [R5] [R9]
    run_wdt_s ##0 sleep_mode |=> watchdog_timeout_flag && powerdown_flag
    && st_r.state == MRC_ST_STARTUP)
    else $error("sleep watchdog flags wrong");

  startup_len_a: assert property ( // see [R6]
    hold_leave_s ##0 (short_startup_cfg && (osc_select == MRC_OSC_EXT_RC
    || osc_select == MRC_OSC_INT_RC))
    |=> st_r.cnt == MRC_CNT_W'(MRC_STARTUP_SHORT_CYCLES))
    else $error("short startup length wrong");

  long_start_a: assert property ( // see [R6] [R7]
    hold_leave_s ##0 !short_startup_cfg
    |=> st_r.cnt == MRC_CNT_W'(MRC_STARTUP_LONG_CYCLES))
    else $error("long startup length wrong");

  crystal_long_a: assert property ( // see [R7]
    hold_leave_s ##0 (osc_select == MRC_OSC_FAST_XTAL
    || osc_select == MRC_OSC_SLOW_XTAL)
    |=> st_r.cnt == MRC_CNT_W'(MRC_STARTUP_LONG_CYCLES))
    else $error("crystal startup not 1024");

  release_end_a: assert property ( // see [R8] [R19]
    release_wait_s ##0 (st_r.cnt == MRC_CNT_W'(1)) |=> core_reset_n)
    else $error("release did not end reset");

  wake_pulse_a: assert property ( // see [R5]
    release_wait_s ##0 (st_r.cnt == MRC_CNT_W'(1)
    && st_r.cause == MRC_CAUSE_WDT_SLEEP)
    |=> sleep_wake_reset_pulse && !full_reset_pulse)
    else $error("sleep wake gave a full reset");

  hold_clears_wdt_a: assert property ( // see [R12]
    !core_reset_n |-> watchdog_clear)
    else $error("watchdog not cleared in reset");

  pin_reset_a: assert property ( // see [R18]
    (!pin_n_s && st_r.state == MRC_ST_RUN) |=> !core_reset_n
    ##1 (st_r.state == MRC_ST_HOLD || st_r.state == MRC_ST_STARTUP))
    else $error("pin reset ignored");

endmodule

// file: verification/mrc_reset_source_model.sv
`timescale 1ns/1ps
module mrc_reset_source_model (
  // clock
  input wire logic clk,
  // reset pin and supply detector
  output logic external_reset_pin_n,
  output logic supply_low
);
  // the pin idles high through its pull-up
  initial begin
    external_reset_pin_n = 1'b1;
    supply_low = 1'b0;
  end
  // hold the pin low for n cycles
  task automatic press_pin(input int n);
    @(negedge clk);
    external_reset_pin_n = 1'b0;
    repeat (n) @(negedge clk);
    external_reset_pin_n = 1'b1;
  endtask
  // supply sits in the low band for n cycles
  task automatic dip(input int n);
    @(negedge clk);
    supply_low = 1'b1;
    repeat (n) @(negedge clk);
    supply_low = 1'b0;
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import mrc_pkg::*;
  localparam int REL = 20;
  logic clk, rst_n, watchdog_timeout, sleep_mode, low_supply_reset_en;
  logic short_startup_cfg, powerdown_set, flags_clear;
  logic external_reset_pin_n, supply_low, core_reset_n, full_reset_pulse;
  logic sleep_wake_reset_pulse, watchdog_clear, watchdog_timeout_flag;
  logic powerdown_flag, timers_stopped;
  logic [1:0] low_supply_threshold_cfg, low_supply_threshold;
  mrc_osc_e osc_select;
  logic [7:0] pc_reset_value, int_enable_value, prescaler_value;
  logic [7:0] port_dir_value, port_data_value, system_control_second;
  logic [7:0] timer0_control, converter_control;
  logic [2:0] sp_reset_value;
  int n_fail, samples_checked, cyc, n_full, n_sleep, t0, t1, k;
  logic [1:0] flg;

  assign flg = {watchdog_timeout_flag, powerdown_flag};

  mrc_reset_ctrl #(.RELEASE_CYCLES(REL)) u_mrc_reset_ctrl (.clk, .rst_n,
    .external_reset_pin_n, .supply_low, .watchdog_timeout, .sleep_mode,
    .low_supply_reset_en, .low_supply_threshold_cfg, .osc_select,
    .short_startup_cfg, .low_supply_threshold, .core_reset_n,
    .full_reset_pulse, .sleep_wake_reset_pulse, .watchdog_clear,
    .watchdog_timeout_flag, .powerdown_flag, .powerdown_set, .flags_clear,
    .pc_reset_value, .sp_reset_value, .int_enable_value, .timers_stopped,
    .prescaler_value, .port_dir_value, .port_data_value,
    .system_control_second, .timer0_control, .converter_control);
  mrc_reset_source_model u_mrc_reset_source_model (.clk,
    .external_reset_pin_n, .supply_low);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard sized for about 4000 cycles of tests
  // sampled just after the edge, so a one-cycle registered pulse counts once
  always @(posedge clk) begin
    #1;
    cyc++;
    if (full_reset_pulse === 1'b1) n_full++;
    if (sleep_wake_reset_pulse === 1'b1) n_sleep++;
    if (cyc == 20000) begin
      n_fail++;
      close_out;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (core_reset_n !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic pin_reset(input mrc_osc_e o, input logic s, output int n);
    osc_select = o;
    short_startup_cfg = s;
    u_mrc_reset_source_model.press_pin(10);
    wait_lvl(1'b1, n);
  endtask

  task automatic pulse_wdt;
    watchdog_timeout = 1'b1;
    @(negedge clk);
    watchdog_timeout = 1'b0;
  endtask

  task automatic test_power_on;
    check("wdt clear held", watchdog_clear, 1);
    check("timers stopped", timers_stopped, 1);
    rst_n = 1'b1;
    wait_lvl(1'b1, t0);
    check("released", core_reset_n, 1);
    check("full pulse", n_full, 1);
    check("timeout flag", watchdog_timeout_flag, 0);
    check("powerdown flag", powerdown_flag, 0);
    check("pc", pc_reset_value, 8'h00);
    check("sp", sp_reset_value, 3'h5);
    check("int enable", int_enable_value, 8'h00);
    check("prescaler", prescaler_value, 8'h00);
    check("port dir", port_dir_value, 8'hFF);
    check("port data", port_data_value, 8'hFF);
    check("sysctrl2", system_control_second, 8'h8A);
    check("timer0 ctrl", timer0_control, 8'h08);
    check("conv ctrl", converter_control, 8'h40);
    check("wdt clear off", watchdog_clear, 0);
    check("timers run", timers_stopped, 0);
    $display("power-on test done");
  endtask

  // only the difference between sources is exact; the pin sync adds slack
  task automatic test_startup;
    pin_reset(MRC_OSC_INT_RC, 1'b1, t0);
    check("short window", t0 >= 2 + REL && t0 <= 8 + REL, 1);
    pin_reset(MRC_OSC_EXT_RC, 1'b1, t1);
    check("ext rc short", t1, t0);
    pin_reset(MRC_OSC_EXT_RC, 1'b0, t1);
    check("ext rc long", t1 - t0, 1022);
    pin_reset(MRC_OSC_FAST_XTAL, 1'b1, t1);
    check("fast xtal", t1 - t0, 1022);
    pin_reset(MRC_OSC_SLOW_XTAL, 1'b1, t1);
    check("slow xtal", t1 - t0, 1022);
    check("pin pulses", n_full, 6);
    $display("start-up test done");
  endtask

  task automatic test_flags;
    osc_select = MRC_OSC_INT_RC;
    short_startup_cfg = 1'b1;
    powerdown_set = 1'b1;
    @(negedge clk);
    powerdown_set = 1'b0;
    pulse_wdt();
    wait_lvl(1'b0, t0);
    wait_lvl(1'b1, t0);
    check("run wdt to", watchdog_timeout_flag, 1);
    check("run wdt pd", powerdown_flag, 1);
    check("run wdt full", n_full, 7);
    pin_reset(MRC_OSC_INT_RC, 1'b1, t0);
    check("pin keeps to", watchdog_timeout_flag, 1);
    check("pin keeps pd", powerdown_flag, 1);
    flags_clear = 1'b1;
    @(negedge clk);
    flags_clear = 1'b0;
    @(negedge clk);
    check("cleared", flg, 0);
    sleep_mode = 1'b1;
    pulse_wdt();
    for (k = 0; k < 3000 && n_sleep == 0; k++) @(negedge clk);
    sleep_mode = 1'b0;
    check("sleep pulse", n_sleep, 1);
    check("no full pulse", n_full, 8);
    check("sleep flags", flg, 3);
    $display("flag test done");
  endtask

  task automatic test_low_supply;
    for (k = 0; k < 4; k++) begin
      low_supply_threshold_cfg = k[1:0];
      @(negedge clk);
      check("threshold", low_supply_threshold, k);
    end
    u_mrc_reset_source_model.dip(90);
    repeat (10) @(negedge clk);
    check("short dip", {core_reset_n, n_full[3:0]}, 5'h18);
    u_mrc_reset_source_model.dip(130);
    check("long dip", core_reset_n, 0);
    wait_lvl(1'b1, t0);
    check("dip release", n_full, 9);
    low_supply_reset_en = 1'b0;
    u_mrc_reset_source_model.dip(200);
    check("disabled", {core_reset_n, n_full[3:0]}, 5'h19);
    $display("low-supply test done");
  endtask

  // a second power-on in mid-run must clear both flags set earlier
  task automatic test_power_again;
    check("flags set", flg, 3);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("por flags", flg, 0);
    check("por holds", core_reset_n, 0);
    rst_n = 1'b1;
    @(negedge clk);
    check("por early", {core_reset_n, watchdog_clear}, 2'h1);
    wait_lvl(1'b1, t0);
    check("por window", t0 >= 2 + REL && t0 <= 8 + REL, 1);
    check("por pulse", n_full, 10);
    check("por flags kept", flg, 0);
    $display("second power-on test done");
  endtask

  initial begin
    {rst_n, watchdog_timeout, sleep_mode, powerdown_set, flags_clear} = 0;
    low_supply_reset_en = 1'b1;
    short_startup_cfg = 1'b1;
    low_supply_threshold_cfg = 2'h0;
    osc_select = MRC_OSC_INT_RC;
    repeat (5) @(negedge clk);
    test_power_on();
    test_startup();
    test_flags();
    test_low_supply();
    test_power_again();
    close_out();
  end
endmodule
